/* imp_pkg.sv */
// Package with constants and types for the interrupt map and priority block
package imp_pkg;
    localparam int NUM_IRQ = 27;            // Mapped IRQ lines 0..26
    localparam int IRQ_W = 32;              // Width of the request vector toward the core
    localparam int PRIO_W = 2;              // Four priority levels
    localparam int NUM_PRIO_REGS = 7;       // priority_regs 0..6
    localparam int IDX_W = 3;
    localparam int VEC_W = 6;
    localparam int FIELD_BASE = 6;          // Field start = 8 * (irq mod 4) + 6
    localparam int FIELD_STRIDE = 8;
    localparam int IRQS_PER_REG = 4;
    localparam logic [VEC_W-1:0] IRQ_VEC_BASE = 6'h10;
    localparam logic [31:0] VEC_TABLE_BASE = 32'h0000_0040;
    localparam logic [31:0] VEC_ENTRY_BYTES = 32'h0000_0004;
    // Core exception vectors
    localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
    localparam logic [VEC_W-1:0] VEC_HARD_FAULT = 6'h03;
    localparam logic [VEC_W-1:0] VEC_SUPERVISOR_CALL = 6'h0b;
    localparam logic [VEC_W-1:0] VEC_PENDABLE_SERVICE_REQUEST = 6'h0e;
    localparam logic [VEC_W-1:0] VEC_SYSTEM_TICK_TIMER = 6'h0f;
    localparam logic [VEC_W-1:0] VEC_NONE = 6'h00;
    localparam logic [31:0] PRIO_RESET = 32'h0000_0000;
    localparam logic [PRIO_W:0] PRIO_NONE = 3'h4;
    // Power modes, ordered from lightest to deepest
    localparam logic [2:0] MODE_RUN = 3'h0;
    localparam logic [2:0] MODE_WAIT = 3'h1;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_VERY_LOW_POWER_STOP = 3'h3;
    localparam logic [2:0] MODE_LOW_LEAK_STOP = 3'h4;
    localparam logic [2:0] MODE_VERY_LOW_LEAK_STOP = 3'h5;

    // Peripheral request lines, all on the core clock
    typedef struct packed {
        logic [3:0] dma_done;
        logic flash_controller;
        logic power_monitor_lvd;
        logic power_monitor_lvw;
        logic low_leak_wakeup_unit;
        logic [1:0] i2c;
        logic [1:0] spi;
        logic [2:0] uart;
        logic adc;
        logic analog_comparator;
        logic [2:0] timer_module;
        logic rtc_alarm;
        logic rtc_seconds;
        logic periodic_timer;
        logic audio_serial;
        logic usb;
        logic dac;
        logic touch_sense_unit;
    } imp_src_t;

    // Core exception requests
    typedef struct packed {
        logic hard_fault;
        logic supervisor_call;
        logic pendable_service_request;
        logic system_tick_timer;
    } imp_core_exc_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [IDX_W-1:0] idx;
        logic [31:0] wdata;
    } imp_reg_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [NUM_IRQ-1:0][PRIO_W-1:0] prio;
        logic nmi_meta;
        logic nmi_sync;
        logic [IRQ_W-1:0] irq_lines;
        logic nmi_req;
        logic wake;
        logic take_valid;
        logic [VEC_W-1:0] take_vec;
        logic [PRIO_W-1:0] take_prio;
        logic [VEC_W-1:0] stacked_vec;
        logic [31:0] stacked_addr;
        logic [31:0] rdata;
    } imp_state_t;
endpackage

/* imp_irq_map.sv */
// Interrupt line map, priority registers, NMI gating and vector selection
`timescale 1ns/1ps

module imp_irq_map (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire imp_pkg::imp_src_t src_in,
    input wire imp_pkg::imp_core_exc_t core_exc_in,
    input wire logic nmi_pin_n_in,
    input wire logic nmi_pin_func_in,
    input wire logic [2:0] power_mode_in,
    input wire logic exc_take_in,
    input wire imp_pkg::imp_reg_req_t reg_in,
    output logic [31:0] reg_rdata_out,
    output logic [imp_pkg::IRQ_W-1:0] irq_lines_out,
    output logic nmi_req_out,
    output logic wake_out,
    output logic exc_valid_out,
    output logic [imp_pkg::VEC_W-1:0] exc_vec_out,
    output logic [imp_pkg::PRIO_W-1:0] exc_prio_out,
    output logic [imp_pkg::VEC_W-1:0] stacked_vec_out,
    output logic [31:0] stacked_addr_out
);
    imp_pkg::imp_state_t state_reg;
    imp_pkg::imp_state_t state_next;

    // Register index holding an IRQ's field
    function automatic int prio_reg_of(input int irq);
        return irq / imp_pkg::IRQS_PER_REG;
    endfunction

    // Bit position of an IRQ's field in its register
    function automatic int field_pos_of(input int irq);
        return imp_pkg::FIELD_STRIDE * (irq % imp_pkg::IRQS_PER_REG)
            + imp_pkg::FIELD_BASE;
    endfunction

    // Vector number of an IRQ
    function automatic logic [imp_pkg::VEC_W-1:0] vec_of(input int irq);
        return imp_pkg::IRQ_VEC_BASE + imp_pkg::VEC_W'(irq);
    endfunction

    // Peripheral sources onto IRQ numbers
    function automatic logic [imp_pkg::IRQ_W-1:0] map_lines(input imp_pkg::imp_src_t s);
        logic [imp_pkg::IRQ_W-1:0] m;
        m = '0;
        m[3:0] = s.dma_done;
        m[4] = 1'b0;
        m[5] = s.flash_controller;
        m[6] = s.power_monitor_lvd | s.power_monitor_lvw;
        m[7] = s.low_leak_wakeup_unit;
        m[9:8] = s.i2c;
        m[11:10] = s.spi;
        m[14:12] = s.uart;
        m[15] = s.adc;
        m[16] = s.analog_comparator;
        m[19:17] = s.timer_module;
        m[20] = s.rtc_alarm;
        m[21] = s.rtc_seconds;
        m[22] = s.periodic_timer;
        m[23] = s.audio_serial;
        m[24] = s.usb;
        m[25] = s.dac;
        m[26] = s.touch_sense_unit;
        return m;
    endfunction

    // Next-state logic
    always_comb begin
        logic [imp_pkg::PRIO_W:0] best_prio;
        logic [imp_pkg::VEC_W-1:0] best_vec;
        logic [31:0] rd_word;
        logic any_req;
        best_prio = imp_pkg::PRIO_NONE;
        best_vec = imp_pkg::VEC_NONE;
        rd_word = '0;
        any_req = 1'b0;
        state_next = state_reg;

        // Pin synchroniser and NMI gating
        state_next.nmi_meta = nmi_pin_n_in;
        state_next.nmi_sync = state_reg.nmi_meta;
        state_next.nmi_req = nmi_pin_func_in & ~state_reg.nmi_sync;

        // Request lines, reserved ones held low
        state_next.irq_lines = map_lines(src_in);

        // Priority register writes, only field bits stored
        for (int i = 0; i < imp_pkg::NUM_IRQ; i++) begin
            if (reg_in.wr && 32'(reg_in.idx) == 32'(prio_reg_of(i))) begin
                state_next.prio[i] = reg_in.wdata[field_pos_of(i) +: imp_pkg::PRIO_W];
            end
        end

        // Priority register reads, other bits zero
        for (int i = 0; i < imp_pkg::NUM_IRQ; i++) begin
            if (32'(reg_in.idx) == 32'(prio_reg_of(i))) begin
                rd_word[field_pos_of(i) +: imp_pkg::PRIO_W] = state_reg.prio[i];
            end
        end
        if (reg_in.rd) begin
            state_next.rdata = rd_word;
        end

        // Lowest field value wins, then lowest IRQ number
        for (int i = 0; i < imp_pkg::NUM_IRQ; i++) begin
            if (state_reg.irq_lines[i] && {1'b0, state_reg.prio[i]} < best_prio) begin
                best_prio = {1'b0, state_reg.prio[i]};
                best_vec = vec_of(i);
            end
        end

        // Core exceptions ahead of peripheral lines
        if (core_exc_in.system_tick_timer) begin
            best_vec = imp_pkg::VEC_SYSTEM_TICK_TIMER;
            best_prio = '0;
        end
        if (core_exc_in.pendable_service_request) begin
            best_vec = imp_pkg::VEC_PENDABLE_SERVICE_REQUEST;
            best_prio = '0;
        end
        if (core_exc_in.supervisor_call) begin
            best_vec = imp_pkg::VEC_SUPERVISOR_CALL;
            best_prio = '0;
        end
        if (core_exc_in.hard_fault) begin
            best_vec = imp_pkg::VEC_HARD_FAULT;
            best_prio = '0;
        end
        if (state_reg.nmi_req) begin
            best_vec = imp_pkg::VEC_NMI;
            best_prio = '0;
        end

        state_next.take_valid = (best_prio != imp_pkg::PRIO_NONE);
        state_next.take_vec = best_vec;
        state_next.take_prio = best_prio[imp_pkg::PRIO_W-1:0];

        // Vector captured for the stack on service
        if (exc_take_in && state_reg.take_valid) begin
            state_next.stacked_vec = state_reg.take_vec;
            state_next.stacked_addr = 32'(state_reg.take_vec) * imp_pkg::VEC_ENTRY_BYTES;
        end

        // Wake-up only in modes down to very-low-power stop
        any_req = (|state_reg.irq_lines) | state_reg.nmi_req;
        state_next.wake = any_req && power_mode_in != imp_pkg::MODE_RUN
            && power_mode_in <= imp_pkg::MODE_VERY_LOW_POWER_STOP;
    end

    // State register with synchronous reset
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
            state_reg.prio <= '{default: imp_pkg::PRIO_W'(imp_pkg::PRIO_RESET)};
            state_reg.nmi_meta <= 1'b1;
            state_reg.nmi_sync <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_out = state_reg.rdata;
    assign irq_lines_out = state_reg.irq_lines;
    assign nmi_req_out = state_reg.nmi_req;
    assign wake_out = state_reg.wake;
    assign exc_valid_out = state_reg.take_valid;
    assign exc_vec_out = state_reg.take_vec;
    assign exc_prio_out = state_reg.take_prio;
    assign stacked_vec_out = state_reg.stacked_vec;
    assign stacked_addr_out = state_reg.stacked_addr;
endmodule

/* imp_irq_map_asserts.sv */
// Port checker for the interrupt map block
`timescale 1ns/1ps
module imp_irq_map_asserts (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire imp_pkg::imp_src_t src_in,
    input wire logic nmi_pin_n_in,
    input wire logic nmi_pin_func_in,
    input wire logic [2:0] power_mode_in,
    input wire logic exc_take_in,
    input wire logic [31:0] irq_lines_out,
    input wire logic nmi_req_out,
    input wire logic wake_out,
    input wire logic exc_valid_out,
    input wire logic [5:0] exc_vec_out,
    input wire logic [5:0] stacked_vec_out,
    input wire logic [31:0] stacked_addr_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    AST_IDLE: assert property (!irq_lines_out[4] && irq_lines_out[31:27] == 5'h0)
        else $error("reserved irq line set");
    AST_DMA: assert property ($past(nrst_in) |-> irq_lines_out[3:0] == $past(src_in.dma_done))
        else $error("dma lines wrong");
    AST_PMC: assert property (src_in.power_monitor_lvd || src_in.power_monitor_lvw |=> irq_lines_out[6])
        else $error("power monitor line missing");
    AST_NMI_GATE: assert property (!nmi_pin_func_in [*4] |-> !nmi_req_out)
        else $error("nmi raised without pin function");
    AST_NMI_RAISE: assert property ((nmi_pin_func_in && !nmi_pin_n_in) [*4] |-> nmi_req_out)
        else $error("nmi missing");
    AST_WAKE: assert property ((power_mode_in == 3'h0 || power_mode_in > 3'h3) [*3] |-> !wake_out)
        else $error("wake in wrong mode");
    AST_TAKE: assert property (exc_take_in && exc_valid_out |=> stacked_vec_out == $past(exc_vec_out)
        && stacked_addr_out == {24'h0, $past(exc_vec_out), 2'h0})
        else $error("stacked value wrong");
    AST_RSVD: assert property (exc_valid_out |-> !(exc_vec_out inside {[6'h0:6'h1], [6'h4:6'ha], 6'hc, 6'hd}))
        else $error("reserved vector");
endmodule
bind imp_irq_map imp_irq_map_asserts u_chk (.*);

/* imp_core_model.sv */
// Core model taking each pending exception once
`timescale 1ns/1ps
module imp_core_model (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic exc_valid_in,
    input wire logic [1:0] delay_in,
    output logic exc_take_out
);
    logic [1:0] wait_reg;
    logic done_reg;
    // Take after delay_in cycles, then wait for valid to drop
    always_ff @(posedge sys_clk_in) begin
        exc_take_out <= 1'b0;
        if (!nrst_in || !exc_valid_in) begin
            wait_reg <= 2'h0;
            done_reg <= 1'b0;
        end else if (!done_reg && wait_reg == delay_in) begin
            exc_take_out <= 1'b1;
            done_reg <= 1'b1;
        end else if (!done_reg) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

/* tb_top.sv */
// Self-checking bench for the interrupt map block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
    logic sys_clk_in = 1'b0, nrst_in = 1'b0, nmi_pin_n_in = 1'b1, nmi_pin_func_in = 1'b0;
    imp_pkg::imp_src_t src_in = '0;
    imp_pkg::imp_core_exc_t core_exc_in = '0;
    imp_pkg::imp_reg_req_t reg_in = '0;
    logic [2:0] power_mode_in = 3'h0;
    logic [31:0] reg_rdata_out, irq_lines_out, stacked_addr_out, q[$], seed = 32'hbe27bd72;
    logic exc_take_in, nmi_req_out, wake_out, exc_valid_out, rd_d = 1'b0, tk_d = 1'b0;
    logic [5:0] exc_vec_out, stacked_vec_out;
    logic [1:0] exc_prio_out, delay = 2'h0;
    int fail_count = 0, comparisons = 0;
    byte irq_of[27] = '{26, 25, 24, 23, 22, 21, 20, 17, 18, 19, 16, 15, 12, 13, 14, 10, 11,
        8, 9, 7, 6, 6, 5, 0, 1, 2, 3};
    byte core_vec[4] = '{3, 11, 14, 15};
    imp_irq_map u_dut (.*);
    imp_core_model u_core (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .exc_valid_in(exc_valid_out),
        .delay_in(delay), .exc_take_out(exc_take_in));
    always #2 sys_clk_in = ~sys_clk_in;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic tick();
        @(posedge sys_clk_in);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic pop(input string n, input logic [31:0] g);
        logic [31:0] e;
        e = q.size() ? q.pop_front() : 'z;
        `CHK(n, e, g)
    endtask
    // Expect lines, vector and table address at the next take
    task automatic await_take(input logic [31:0] lines, input logic [31:0] vec,
        input logic wk, input logic nm);
        int n;
        q.push_back({30'h0, wk, nm});
        q.push_back(lines);
        q.push_back(vec);
        q.push_back(vec << 2);
        n = 0;
        while (!(exc_take_in === 1'b1 && exc_valid_out === 1'b1) && n < 20) begin
            tick();
            n++;
        end
        if (n == 20) begin
            fail_count++;
            finish_test();
        end
        tick();
    endtask
    // Compare results against the oldest notes as they appear
    always @(negedge sys_clk_in) begin
        if (rd_d) pop("rdata", reg_rdata_out);
        if (tk_d) begin
            pop("wake_nmi", {30'h0, wake_out, nmi_req_out});
            pop("lines", irq_lines_out);
            pop("vec", {26'h0, stacked_vec_out});
            pop("addr", stacked_addr_out);
        end
        rd_d = reg_in.rd;
        tk_d = exc_take_in === 1'b1 && exc_valid_out === 1'b1;
    end
    // Registers, every source line, NMI gating, then core exceptions
    initial begin
        repeat (10) tick();
        nrst_in = 1'b1;
        tick();
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            reg_in = '{1'b1, 1'b0, 3'(i), seed};
            tick();
            reg_in = '{1'b0, 1'b1, 3'(i), 32'h0};
            q.push_back(i == 7 ? 32'h0 : seed & (i == 6 ? 32'h00c0c0c0 : 32'hc0c0c0c0));
            tick();
        end
        reg_in = '0;
        for (int b = 0; b < 27; b++) begin
            seed = xs(seed);
            delay = seed[1:0];
            power_mode_in = 3'(b % 6);
            src_in = imp_pkg::imp_src_t'(27'h1 << b);
            await_take(32'h1 << irq_of[b], 32'(irq_of[b]) + 32'h10,
                power_mode_in inside {3'h1, 3'h2, 3'h3}, 1'b0);
            src_in = '0;
            repeat (4) tick();
        end
        nmi_pin_n_in = 1'b0;
        repeat (6) tick();
        nmi_pin_func_in = 1'b1;
        await_take(32'h0, 32'h2, 1'b1, 1'b1);
        nmi_pin_n_in = 1'b1;
        repeat (6) tick();
        for (int i = 0; i < 4; i++) begin
            core_exc_in = imp_pkg::imp_core_exc_t'(4'h8 >> i);
            await_take(32'h0, 32'(core_vec[i]), 1'b0, 1'b0);
            core_exc_in = '0;
            repeat (4) tick();
        end
        finish_test();
    end
endmodule
